// >>> rtl/usb_error_status_control_regs.sv
// Error interrupt mask, transfer status queue and control upper bits.
// Assumes an APB master on pclk, error flags held by a neighbour register,
// and line states arriving asynchronously from the transceiver.
//
// Function
// - Bit 7 enables bit stuff error
// - Bit 6 enables bus matrix error
// - Bit 5 enables DMA error
// - Bit 4 enables turnaround time-out error
// - Bit 3 enables field size error
// - Bit 2 enables data CRC error
// - Device mode: bit 1 enables token CRC
// - Host mode: bit 1 enables frame end
// - Bit 0 enables PID check error
// - Main error enable qualifies combined interrupt
// - Bits 31 to 8 read zero
// - Status bits 7-4 give endpoint
// - Status bit 3 gives transmit direction
// - Bit 2 odd bank; bits 1-0 zero
// - Status shows head of four-deep queue
// - Status valid only while token done set
// - Clearing token done pops the queue
// - Control bit 7 shows live J state
// - Control bit 6 shows live SE0
// - Device: bit 5 holds processing, set on SETUP
// - Host: bit 5 shows token busy
`timescale 1ns/100ps
module usb_error_status_control_regs (
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [usb_regs_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [usb_regs_pkg::DATA_W-1:0]   pwdata,
   input  wire logic [3:0]                        pstrb,
   output logic      [usb_regs_pkg::DATA_W-1:0]   prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   input  wire logic                              host_mode,
   input  wire logic                              stuff_err_flag,
   input  wire logic                              matrix_err_flag,
   input  wire logic                              dma_err_flag,
   input  wire logic                              turnaround_err_flag,
   input  wire logic                              field_size_err_flag,
   input  wire logic                              data_crc_err_flag,
   input  wire logic                              token_crc_err_flag,
   input  wire logic                              frame_end_err_flag,
   input  wire logic                              pid_check_err_flag,
   input  wire logic                              xfer_done,
   input  wire logic [3:0]                        xfer_endpoint,
   input  wire logic                              xfer_tx,
   input  wire logic                              xfer_odd,
   input  wire logic                              setup_rx,
   input  wire logic                              token_busy,
   input  wire logic                              line_j,
   input  wire logic                              line_se0,
   output logic                                   error_irq,
   output logic                                   combined_usb_irq,
   output logic                                   packet_processing_hold,
   output logic                                   token_done_flag,
   output logic                                   status_fifo_full
);
   import usb_regs_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] offs);
      addr_is = (a == offs);
   endfunction

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      addr_mapped = addr_is(a, ERR_EN_OFFSET) | addr_is(a, STATUS_OFFSET) |
                    addr_is(a, CONTROL_OFFSET) | addr_is(a, MAIN_IE_OFFSET) |
                    addr_is(a, MAIN_IF_OFFSET);
   endfunction

   // ==========================================================
   // State
   logic [FIELD_W-1:0]  err_en;
   logic [FIELD_W-1:0]  next_err_en;
   logic                main_error_irq_en;
   logic                next_main_error_irq_en;
   logic                next_hold;
   logic                next_token_done;
   logic                next_error_irq;
   logic                next_combined_irq;
   logic [ENTRY_W-1:0]  fifo_mem [FIFO_DEPTH];
   logic [ENTRY_W-1:0]  next_entry;
   logic [PTR_W-1:0]    wr_ptr;
   logic [PTR_W-1:0]    next_wr_ptr;
   logic [PTR_W-1:0]    rd_ptr;
   logic [PTR_W-1:0]    next_rd_ptr;
   logic [CNT_W-1:0]    count;
   logic [CNT_W-1:0]    next_count;
   logic [DATA_W-1:0]   next_prdata;
   logic                j_s1;
   logic                j_s2;
   logic                j_s3;
   logic                live_j_state;
   logic                next_live_j;
   logic                se0_s1;
   logic                se0_s2;
   logic                se0_s3;
   logic                live_single_ended_zero;
   logic                next_live_se0;
   logic [FIELD_W-1:0]  flags;
   logic [ENTRY_W-1:0]  head;
   logic                wr_acc;
   logic                setup_phase;
   logic                push;
   logic                pop;
   logic [FIELD_W-1:0]  status_view;
   logic [FIELD_W-1:0]  control_view;

   // ==========================================================
   // Flag vector, shared bit follows the mode
   assign flags[STUFF_BIT]      = stuff_err_flag;
   assign flags[MATRIX_BIT]     = matrix_err_flag;
   assign flags[DMA_BIT]        = dma_err_flag;
   assign flags[TURNAROUND_BIT] = turnaround_err_flag;
   assign flags[FIELD_SIZE_BIT] = field_size_err_flag;
   assign flags[DATA_CRC_BIT]   = data_crc_err_flag;
   assign flags[SHARED_BIT]     = host_mode ? frame_end_err_flag
                                            : token_crc_err_flag;
   assign flags[PID_CHECK_BIT]  = pid_check_err_flag;

   // ==========================================================
   // APB decode; zero wait states, so pready is tied high
   assign pready      = 1'b1;
   assign pslverr     = psel & penable & ~addr_mapped(paddr);
   assign setup_phase = psel & ~penable;
   assign wr_acc      = psel & penable & pwrite & pstrb[0];
   assign head        = fifo_mem[rd_ptr];

   // Stale entries hidden while the queue is empty
   assign status_view = (count != CNT_ZERO) ?
                        {head, 2'b00} : 8'h00;
   assign control_view = {live_j_state,
                          live_single_ended_zero,
                          host_mode ? token_busy
                                    : packet_processing_hold,
                          5'b0_0000};

   // ==========================================================
   // Register, queue and interrupt next values
   always_comb begin
      next_err_en            = err_en;
      next_main_error_irq_en = main_error_irq_en;
      next_hold              = packet_processing_hold;
      next_prdata            = prdata;
      if (wr_acc && addr_is(paddr, ERR_EN_OFFSET)) begin
         next_err_en = pwdata[FIELD_W-1:0];
      end
      if (wr_acc && addr_is(paddr, MAIN_IE_OFFSET)) begin
         next_main_error_irq_en = pwdata[MAIN_ERR_IE_BIT];
      end
      if (wr_acc && addr_is(paddr, CONTROL_OFFSET)) begin
         next_hold = pwdata[CTRL_HOLD_BIT];
      end
      // A SETUP arriving with a clear still holds the core
      if (setup_rx) begin
         next_hold = 1'b1;
      end
      if (host_mode) begin
         next_hold = 1'b0;
      end

      // Read data latched in setup so it is stable through access
      if (setup_phase) begin
         next_prdata = READ_ZERO;
         if (addr_is(paddr, ERR_EN_OFFSET)) begin
            next_prdata = {UPPER_ZERO, err_en};
         end else if (addr_is(paddr, STATUS_OFFSET)) begin
            next_prdata = {UPPER_ZERO, status_view};
         end else if (addr_is(paddr, CONTROL_OFFSET)) begin
            next_prdata = {UPPER_ZERO, control_view};
         end else if (addr_is(paddr, MAIN_IE_OFFSET)) begin
            next_prdata = READ_ZERO;
            next_prdata[MAIN_ERR_IE_BIT] = main_error_irq_en;
         end else if (addr_is(paddr, MAIN_IF_OFFSET)) begin
            next_prdata = READ_ZERO;
            next_prdata[TOKEN_DONE_BIT] = token_done_flag;
         end
      end

      // Queue: full queue drops only if no pop frees a slot
      pop  = wr_acc & addr_is(paddr, MAIN_IF_OFFSET) &
             pwdata[TOKEN_DONE_BIT] & token_done_flag;
      push = xfer_done & ((count != FIFO_FULL) | pop);
      next_entry  = {xfer_endpoint, xfer_tx, xfer_odd};
      next_wr_ptr = push ? wr_ptr + PTR_ONE : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + PTR_ONE : rd_ptr;
      next_count  = count;
      if (push && !pop) begin
         next_count = count + CNT_ONE;
      end else if (pop && !push) begin
         next_count = count - CNT_ONE;
      end

      // Flag re-asserts at once when entries remain after a pop
      if (pop) begin
         next_token_done = (next_count != CNT_ZERO);
      end else begin
         next_token_done = token_done_flag | (count != CNT_ZERO);
      end

      next_error_irq    = |(flags & err_en);
      next_combined_irq = next_error_irq & main_error_irq_en;

      // Three-stage sampling; a change counts once stages two and three agree
      next_live_j   = (j_s2 == j_s3) ? j_s3 : live_j_state;
      next_live_se0 = (se0_s2 == se0_s3) ? se0_s3 : live_single_ended_zero;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_en                 <= ERR_EN_RESET;
         main_error_irq_en      <= 1'b0;
         packet_processing_hold <= 1'b0;
         token_done_flag        <= 1'b0;
         error_irq              <= 1'b0;
         combined_usb_irq       <= 1'b0;
         wr_ptr                 <= '0;
         rd_ptr                 <= '0;
         count                  <= CNT_ZERO;
         prdata                 <= READ_ZERO;
         j_s1                   <= 1'b0;
         j_s2                   <= 1'b0;
         j_s3                   <= 1'b0;
         live_j_state           <= 1'b0;
         se0_s1                 <= 1'b0;
         se0_s2                 <= 1'b0;
         se0_s3                 <= 1'b0;
         live_single_ended_zero <= 1'b0;
      end else begin
         err_en                 <= next_err_en;
         main_error_irq_en      <= next_main_error_irq_en;
         packet_processing_hold <= next_hold;
         token_done_flag        <= next_token_done;
         error_irq              <= next_error_irq;
         combined_usb_irq       <= next_combined_irq;
         wr_ptr                 <= next_wr_ptr;
         rd_ptr                 <= next_rd_ptr;
         count                  <= next_count;
         prdata                 <= next_prdata;
         j_s1                   <= line_j;
         j_s2                   <= j_s1;
         j_s3                   <= j_s2;
         live_j_state           <= next_live_j;
         se0_s1                 <= line_se0;
         se0_s2                 <= se0_s1;
         se0_s3                 <= se0_s2;
         live_single_ended_zero <= next_live_se0;
      end
   end

   // Storage without reset; entries are hidden while the queue is empty
   always_ff @(posedge pclk) begin
      if (push) begin
         fifo_mem[wr_ptr] <= next_entry;
      end
   end

   assign status_fifo_full = (count == FIFO_FULL);

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_clear_done;
      pop && !push;
   endsequence

   sequence s_ctrl_setup;
      psel && !penable && addr_is(paddr, CONTROL_OFFSET);
   endsequence

   a_stuff_gate: assert property (
      stuff_err_flag && err_en[STUFF_BIT] |=> error_irq)
      else $error("stuff error not raised");
   a_mask_blocks: assert property (
      (err_en == 8'h00) |=> !error_irq)
      else $error("masked error raised irq");
   a_dma_gate: assert property (
      dma_err_flag && err_en[DMA_BIT] |=> error_irq)
      else $error("dma error not raised");
   a_crc5_device: assert property (
      !host_mode && token_crc_err_flag && err_en[SHARED_BIT] |=> error_irq)
      else $error("token crc not raised");
   a_eof_host: assert property (
      host_mode && frame_end_err_flag && err_en[SHARED_BIT] |=> error_irq)
      else $error("frame end not raised");
   a_main_gate: assert property (
      combined_usb_irq |-> error_irq && $past(main_error_irq_en))
      else $error("combined irq without main enable");
   a_upper_zero: assert property (
      psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   a_stat_low: assert property (
      psel && !penable && addr_is(paddr, STATUS_OFFSET)
      |=> prdata[1:0] == 2'b00)
      else $error("status low bits not zero");
   a_queue_bound: assert property (
      count <= FIFO_FULL)
      else $error("queue overflow");
   a_empty_flag: assert property (
      count == CNT_ZERO |-> !token_done_flag)
      else $error("token done with empty queue");
   a_pop_advance: assert property (
      s_clear_done |=> count == $past(count) - CNT_ONE)
      else $error("clear did not pop");
   a_setup_hold: assert property (
      setup_rx && !host_mode |=> packet_processing_hold [*1] ##0
      control_view[CTRL_HOLD_BIT])
      else $error("setup did not hold");
   a_host_busy: assert property (
      s_ctrl_setup ##0 host_mode |=> prdata[CTRL_HOLD_BIT] == $past(token_busy))
      else $error("busy not shown");
   a_live_j: assert property (
      line_j [*5] |-> live_j_state)
      else $error("j state not followed");

   sequence s_stat_setup;
      psel && !penable && addr_is(paddr, STATUS_OFFSET);
   endsequence

   a_matrix_gate: assert property (
      matrix_err_flag && err_en[MATRIX_BIT] |=> error_irq)
      else $error("matrix error not raised");
   a_turn_gate: assert property (
      turnaround_err_flag && err_en[TURNAROUND_BIT] |=> error_irq)
      else $error("turnaround error not raised");
   a_size_gate: assert property (
      field_size_err_flag && err_en[FIELD_SIZE_BIT] |=> error_irq)
      else $error("field size error not raised");
   a_crc16_gate: assert property (
      data_crc_err_flag && err_en[DATA_CRC_BIT] |=> error_irq)
      else $error("data crc error not raised");
   a_pid_gate: assert property (
      pid_check_err_flag && err_en[PID_CHECK_BIT] |=> error_irq)
      else $error("pid error not raised");
   a_main_block: assert property (
      !main_error_irq_en |=> !combined_usb_irq)
      else $error("combined irq with main enable off");
   a_stat_fields: assert property (
      s_stat_setup ##0 count != CNT_ZERO |=> prdata[FIELD_W-1:STAT_BANK_BIT] == $past(head))
      else $error("status fields wrong");
   a_stat_empty: assert property (
      s_stat_setup ##0 count == CNT_ZERO |=> prdata == READ_ZERO)
      else $error("empty status not zero");
   a_done_rise: assert property (
      count != CNT_ZERO && !pop |=> token_done_flag)
      else $error("token done not raised");
   a_write_pop: assert property (
      wr_acc && addr_is(paddr, MAIN_IF_OFFSET) && pwdata[TOKEN_DONE_BIT] && token_done_flag
      && !xfer_done |=> count == $past(count) - CNT_ONE)
      else $error("clear write did not pop");
   a_full_drop: assert property (
      status_fifo_full && xfer_done && !wr_acc |=> status_fifo_full)
      else $error("full queue changed on drop");
   a_live_j_low: assert property (
      (!line_j) [*5] |-> !live_j_state)
      else $error("j state stuck high");
   a_live_se0: assert property (
      line_se0 [*5] |-> live_single_ended_zero)
      else $error("se0 not followed");
   a_hold_clear: assert property (
      wr_acc && addr_is(paddr, CONTROL_OFFSET) && !pwdata[CTRL_HOLD_BIT] && !setup_rx
      |=> !packet_processing_hold)
      else $error("hold not cleared");
   a_host_no_hold: assert property (
      host_mode |=> !packet_processing_hold)
      else $error("hold set in host mode");

endmodule

// >>> rtl/usb_regs_pkg.sv
// Package for the USB error, status and control register slice.
// Assumes an APB master on pclk and a USB core that reports events as pulses.
package usb_regs_pkg;

   // ==========================================================
   // Register byte offsets on the APB bus
   localparam logic [7:0] ERR_EN_OFFSET  = 8'h00;
   localparam logic [7:0] STATUS_OFFSET  = 8'h04;
   localparam logic [7:0] CONTROL_OFFSET = 8'h08;
   localparam logic [7:0] MAIN_IE_OFFSET = 8'h0C;
   localparam logic [7:0] MAIN_IF_OFFSET = 8'h10;

   // ==========================================================
   // Widths and reset values
   localparam int unsigned   ADDR_W        = 8;
   localparam int unsigned   DATA_W        = 32;
   localparam int unsigned   FIELD_W       = 8;
   localparam logic [7:0]    ERR_EN_RESET  = 8'h00;
   localparam logic [31:0]   READ_ZERO     = 32'h0000_0000;
   localparam logic [23:0]   UPPER_ZERO    = 24'h00_0000;

   // ==========================================================
   // Error enable bit positions
   localparam int unsigned STUFF_BIT      = 7;
   localparam int unsigned MATRIX_BIT     = 6;
   localparam int unsigned DMA_BIT        = 5;
   localparam int unsigned TURNAROUND_BIT = 4;
   localparam int unsigned FIELD_SIZE_BIT = 3;
   localparam int unsigned DATA_CRC_BIT   = 2;
   localparam int unsigned SHARED_BIT     = 1;
   localparam int unsigned PID_CHECK_BIT  = 0;

   // ==========================================================
   // Status, control and main register bit positions
   localparam int unsigned STAT_EP_LSB     = 4;
   localparam int unsigned STAT_DIR_BIT    = 3;
   localparam int unsigned STAT_BANK_BIT   = 2;
   localparam int unsigned CTRL_J_BIT      = 7;
   localparam int unsigned CTRL_SE0_BIT    = 6;
   localparam int unsigned CTRL_HOLD_BIT   = 5;
   localparam int unsigned MAIN_ERR_IE_BIT = 1;
   localparam int unsigned TOKEN_DONE_BIT  = 3;

   // ==========================================================
   // Completion queue shape
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned PTR_W      = 2;
   localparam int unsigned CNT_W      = 3;
   localparam int unsigned ENTRY_W    = 6;
   localparam logic [2:0]  FIFO_FULL  = 3'h4;
   localparam logic [2:0]  CNT_ZERO   = 3'h0;
   localparam logic [2:0]  CNT_ONE    = 3'h1;
   localparam logic [1:0]  PTR_ONE    = 2'h1;

endpackage

// >>> testbench/tb_usb_error_status_control_regs.sv
// Self-checking bench for the USB error, status and control register slice.
// Assumes the far-side model usb_far_model and the package usb_regs_pkg.
`timescale 1ns/100ps
module tb_usb_error_status_control_regs;
   import usb_regs_pkg::*;
   // ==========================================================
   // Signals
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, rdata, seed;
   logic [3:0]        pstrb;
   logic              host_mode, xfer_done, xfer_tx, xfer_odd, setup_rx, token_busy;
   logic              line_j, line_se0, error_irq, combined_usb_irq;
   logic              packet_processing_hold, token_done_flag, status_fifo_full;
   logic [8:0]        flags, fl;
   logic [3:0]        xfer_endpoint;
   logic [7:0]        en;
   logic [5:0]        ent;
   logic [5:0]        q[$];
   logic              last_err, xi;
   int                error_cnt, checks_done, m, i, k, si, n;
   localparam logic [7:0] ADDRS [5] = '{ERR_EN_OFFSET, STATUS_OFFSET, CONTROL_OFFSET,
                                        MAIN_IE_OFFSET, MAIN_IF_OFFSET};

   usb_error_status_control_regs DUT (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .host_mode, .stuff_err_flag(flags[7]), .matrix_err_flag(flags[6]),
      .dma_err_flag(flags[5]), .turnaround_err_flag(flags[4]), .field_size_err_flag(flags[3]),
      .data_crc_err_flag(flags[2]), .token_crc_err_flag(flags[1]),
      .frame_end_err_flag(flags[8]), .pid_check_err_flag(flags[0]), .xfer_done,
      .xfer_endpoint, .xfer_tx, .xfer_odd, .setup_rx, .token_busy, .line_j, .line_se0,
      .error_irq, .combined_usb_irq, .packet_processing_hold, .token_done_flag,
      .status_fifo_full);
   usb_far_model far (.pclk, .flags, .xfer_done, .xfer_endpoint, .xfer_tx, .xfer_odd,
      .setup_rx, .token_busy, .line_j, .line_se0);

   // ==========================================================
   // Helpers
   always #2 pclk = ~pclk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0000_0000);
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask
   // Master waits on pready, never on a fixed count
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic conclude();
      if (error_cnt == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, host_mode} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
      error_cnt = 0;
      checks_done = 0;
      seed = 32'h0000_7128;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ADDRS[a]) begin
         apb(1'b0, ADDRS[a], 32'h0000_0000);
         check("reset value", 0, rdata);
      end
      // Every mask bit, both modes, main enable off and on
      for (int idx = 0; idx < 96; idx++) begin
         m = idx / 24;
         i = (idx / 3) % 8;
         k = idx % 3;
         if (k == 0 && i == 0) begin
            @(posedge pclk);
            host_mode <= m[0];
            apb(1'b1, MAIN_IE_OFFSET, m[1] ? 32'h0000_0002 : 32'h0000_0000);
         end
         si = (i == 1 && m[0]) ? 8 : i;
         seed = lfsr(seed);
         en = (k == 1) ? ~(8'h01 << i) : (8'h01 << i);
         fl = (k == 0) ? (seed[8:0] | (9'h001 << si)) : (k == 1) ? (9'h001 << si) : ~(9'h001 << si);
         far.set_flags(fl);
         apb(1'b1, ERR_EN_OFFSET, {seed[31:8], en});
         apb(1'b0, ERR_EN_OFFSET, 32'h0000_0000);
         check("enable readback", {24'h00_0000, en}, rdata);
         idle(2);
         xi = |(en & {fl[7:2], m[0] ? fl[8] : fl[1], fl[0]});
         if (i > 3) check("irq", xi, error_irq);
         if (i < 4) check("irq", xi, error_irq);
         check("combined", xi & m[1], combined_usb_irq);
      end
      // Completion queue: overfill by one, then drain in order
      @(posedge pclk);
      host_mode <= 1'b0;
      for (int p = 0; p < 5; p++) begin
         seed = lfsr(seed);
         far.push(seed[5:0]);
         if (q.size() < FIFO_DEPTH) q.push_back(seed[5:0]);
      end
      idle(3);
      check("full", 1, status_fifo_full);
      apb(1'b1, STATUS_OFFSET, seed);
      while (q.size() > 0) begin
         apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
         check("status", {24'h00_0000, q[0], 2'b00}, rdata);
         check("token done", 1, token_done_flag);
         apb(1'b1, MAIN_IF_OFFSET, 32'h0000_0008);
         ent = q.pop_front();
         idle(2);
         check("done after pop", q.size() != 0, token_done_flag);
      end
      apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
      check("empty status", 0, rdata);
      check("not full", 0, status_fifo_full);
      // Live line states, ending idle
      for (int c = 3; c >= 0; c--) begin
         far.set_lines(c[1], c[0], 1'b0);
         idle(6);
         apb(1'b0, CONTROL_OFFSET, 32'h0000_0000);
         check("lines", {24'h00_0000, c[1], c[0], 6'h00}, rdata);
      end
      // Device hold set by SETUP, cleared by software
      far.pulse_setup();
      idle(2);
      check("hold", 1, packet_processing_hold);
      apb(1'b0, CONTROL_OFFSET, 32'h0000_0000);
      check("hold bit", 32'h0000_0020, rdata);
      apb(1'b1, CONTROL_OFFSET, 32'h0000_0000);
      idle(2);
      check("hold clear", 0, packet_processing_hold);
      // Host token busy, with a SETUP that must not hold
      @(posedge pclk);
      host_mode <= 1'b1;
      far.set_lines(1'b0, 1'b0, 1'b1);
      far.pulse_setup();
      idle(3);
      apb(1'b0, CONTROL_OFFSET, 32'h0000_0000);
      check("busy", 32'h0000_0020, rdata);
      check("host hold", 0, packet_processing_hold);
      far.set_lines(1'b0, 1'b0, 1'b0);
      n = 0;
      do begin
         apb(1'b0, CONTROL_OFFSET, 32'h0000_0000);
         n++;
      end while (rdata[5] !== 1'b0 && n < 10);
      check("busy clear", 0, rdata);
      // Unmapped place refuses
      apb(1'b1, 8'h20, 32'hffff_ffff);
      check("slverr", 1, last_err);
      apb(1'b0, 8'h20, 32'h0000_0000);
      check("unmapped read", 0, rdata);
      conclude();
   end

   // ==========================================================
   // Hang guard, well beyond the thousand or so cycles needed
   initial begin
      #200_000;
      error_cnt++;
      conclude();
   end
endmodule

// >>> testbench/usb_far_model.sv
// Far-side model: USB engine and transceiver as seen by the register slice.
// Assumes the bench calls its tasks from one process synchronous to pclk.
`timescale 1ns/100ps
module usb_far_model (
   input  wire logic       pclk,
   output logic [8:0]      flags,
   output logic            xfer_done,
   output logic [3:0]      xfer_endpoint,
   output logic            xfer_tx,
   output logic            xfer_odd,
   output logic            setup_rx,
   output logic            token_busy,
   output logic            line_j,
   output logic            line_se0
);
   // ==========================================================
   // Idle levels at time zero
   initial begin
      flags = 9'h000;
      xfer_done = 1'b0;
      {xfer_endpoint, xfer_tx, xfer_odd} = 6'h00;
      setup_rx = 1'b0;
      token_busy = 1'b0;
      line_j = 1'b0;
      line_se0 = 1'b0;
   end
   // ==========================================================
   // Events, one cycle wide
   task automatic push(input logic [5:0] entry);
      @(posedge pclk);
      xfer_done <= 1'b1;
      {xfer_endpoint, xfer_tx, xfer_odd} <= entry;
      @(posedge pclk);
      xfer_done <= 1'b0;
      // Stale fields scrambled so nothing leans on them
      {xfer_endpoint, xfer_tx, xfer_odd} <= ~entry;
   endtask
   task automatic pulse_setup();
      @(posedge pclk);
      setup_rx <= 1'b1;
      @(posedge pclk);
      setup_rx <= 1'b0;
   endtask
   // ==========================================================
   // Levels
   task automatic set_flags(input logic [8:0] f);
      @(posedge pclk);
      flags <= f;
   endtask
   task automatic set_lines(input logic j, input logic se0, input logic busy);
      @(posedge pclk);
      line_j <= j;
      line_se0 <= se0;
      token_busy <= busy;
   endtask
endmodule
